// *** shared/uwr_pkg.sv ***
// Shared constants and types for the serial wake receiver
package uwr_pkg;

   // -------------------------------------------------------------
   // Register map (word addresses on the plain register port)
   // -------------------------------------------------------------
   localparam logic [3:0] UWR_ADDR_CTRL = 4'h0;
   localparam logic [3:0] UWR_ADDR_BAUD = 4'h1;
   localparam logic [3:0] UWR_ADDR_STAT = 4'h2;
   localparam logic [3:0] UWR_ADDR_MASK = 4'h3;
   localparam logic [3:0] UWR_ADDR_DATA = 4'h4;
   localparam logic [3:0] UWR_ADDR_RTCP = 4'h5;
   localparam logic [3:0] UWR_ADDR_TXD = 4'h6;

   // -------------------------------------------------------------
   // Control fields
   // -------------------------------------------------------------
   localparam int UWR_CTRL_RXEN = 0;
   localparam int UWR_CTRL_DSPD = 1;
   localparam int UWR_CTRL_SFDE = 2;
   localparam int UWR_CTRL_STBY = 3;
   localparam int UWR_CTRL_RUN_IN_STANDBY = 4;
   localparam int UWR_CTRL_LINKUP = 5;
   localparam int UWR_CTRL_XFER = 6;
   localparam logic [7:0] UWR_CTRL_RESET = 8'h00;

   // Status / mask bit positions
   localparam int UWR_ST_RXC = 0;
   localparam int UWR_ST_RXS = 1;
   localparam int UWR_ST_RTC = 2;
   localparam int UWR_ST_PIN = 3;
   localparam int UWR_ST_FERR = 4;
   localparam int UWR_ST_W = 5;
   localparam logic [4:0] UWR_MASK_RESET = 5'h00;

   // -------------------------------------------------------------
   // Timing: 25 MHz system clock, 38400 baud
   // -------------------------------------------------------------
   localparam int UWR_CLK_HZ = 25000000;
   localparam int UWR_BAUD = 38400;
   localparam int UWR_OVS_NORMAL = 16;
   localparam int UWR_OVS_DOUBLE = 8;
   // Sample period count for 16x oversampling, rounded down
   localparam int UWR_SAMPLE_DIV = UWR_CLK_HZ / (UWR_BAUD * UWR_OVS_NORMAL);
   localparam logic [15:0] UWR_BAUD_RESET = 16'(UWR_SAMPLE_DIV);
   // Wake-up: six peripheral clocks + analog start + four osc cycles
   localparam int UWR_WAKE_CLK_CYC = 6;
   localparam int UWR_OSC_START_NS = 8000;
   localparam int UWR_OSC_EXTRA_CYC = 4;
   localparam int UWR_CLK_NS = 40;
   localparam int UWR_WAKE_CYC = UWR_WAKE_CLK_CYC
      + (UWR_OSC_START_NS + UWR_CLK_NS - 1) / UWR_CLK_NS + UWR_OSC_EXTRA_CYC;
   localparam logic [31:0] UWR_RTC_RESET = 32'h0000FFFF;

   // Receiver states
   typedef enum logic [3:0] {
      UWR_IDLE = 4'b0001,
      UWR_START = 4'b0010,
      UWR_DATA = 4'b0100,
      UWR_STOP = 4'b1000
   } uwr_rx_state_t;

endpackage

// *** hdl/uwr_sync.sv ***
// Two-flip-flop synchroniser for one pin input
`timescale 1ns/1ps
module uwr_sync
   import uwr_pkg::*;
#(
   parameter logic INIT = 1'b1
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   // Data
   input wire logic din,
   output logic dout
);

   logic meta;

   // First stage feeds only the second stage
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta <= INIT;
         dout <= INIT;
      end
      else if (clk_en)
      begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule

// *** hdl/uwr_wake.sv ***
// Standby wake sequencer: holds the oscillator-ready delay after a wake
`timescale 1ns/1ps
module uwr_wake
   import uwr_pkg::*;
#(
   parameter int WAKE_CYC = UWR_WAKE_CYC
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   // Control
   input wire logic sleep_req,
   input wire logic wake_evt,
   // Status
   output logic asleep,
   output logic clk_ready
);

   logic [9:0] cnt;
   wire count_done = (cnt == 10'h000);

   // Restart count models clock tree plus oscillator start-up
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         asleep <= 1'b0;
         cnt <= 10'h000;
         clk_ready <= 1'b1;
      end
      else if (clk_en)
      begin
         if (asleep && wake_evt)
         begin
            asleep <= 1'b0;
            cnt <= 10'(WAKE_CYC); // R8
            clk_ready <= 1'b0;
         end
         else if (!asleep && sleep_req && clk_ready && !wake_evt)
         begin
            asleep <= 1'b1;
            clk_ready <= 1'b0;
         end
         else if (!asleep && !clk_ready)
         begin
            if (count_done)
               clk_ready <= 1'b1;
            else
               cnt <= cnt - 10'h001;
         end
      end
   end

endmodule

// *** hdl/uwr_top.sv ***
// Serial wake receiver: oversampled start detect, RX, wake sources
//
// How it works
// R1 - Sample line at 16x baud, or 8x in double-speed mode.
// R2 - Vote start on samples 8,9,10 (normal) or 4,5,6 (double).
// R3 - Accept start only if two or three votes are low.
// R4 - Rejected start returns to idle, waits next fall, no event.
// R5 - Start detect on, start irq off, complete irq on wakes all clocks.
// R6 - Receive-complete and start-of-frame share one interrupt line.
// R7 - Start-of-frame wakes host from standby; that byte is received.
// R8 - Wake takes six clocks plus oscillator start; within six samples.
// R9 - Link runs at 38400 bits per second on both ends.
// R10 - Periodic counter runs in standby when enabled; overflow wakes.
// R11 - Motion pin change wakes the host from standby.
// R12 - Module stays low-frequency while indication line is high.
// R13 - Module resumes high-frequency when indication line goes low.
// R14 - Drive indication low before a transfer, high after it.
// R15 - Send data to module only while radio link is up.
// R16 - Configuration command enabling dual-frequency goes over serial.
`timescale 1ns/1ps
module uwr_top
   import uwr_pkg::*;
#(
   parameter logic [15:0] BAUD_DIV = UWR_BAUD_RESET,
   parameter logic [31:0] RTC_PERIOD = UWR_RTC_RESET
)
(
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Serial link and pins
   input wire logic serial_rx,
   input wire logic motion_int,
   output logic host_rx_indication,
   // System
   output logic irq,
   output logic asleep,
   output logic tx_req,
   output logic [7:0] tx_byte
);

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   logic rx_s;
   logic motion_s;

   uwr_sync #(.INIT(1'b1)) u_sync_rx
   (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .din(serial_rx),
      .dout(rx_s)
   );

   uwr_sync #(.INIT(1'b1)) u_sync_mot
   (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .din(motion_int),
      .dout(motion_s)
   );

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   logic [7:0] ctrl;
   logic [15:0] baud_div;
   logic [4:0] status;
   logic [4:0] mask;
   logic [7:0] rx_data;
   logic [31:0] rtc_period;
   logic [31:0] rtc_cnt;
   logic rx_prev;
   logic motion_prev;

   wire dspd = ctrl[UWR_CTRL_DSPD];
   wire sfde = ctrl[UWR_CTRL_SFDE];
   wire rx_en = ctrl[UWR_CTRL_RXEN];
   wire link_up = ctrl[UWR_CTRL_LINKUP];
   wire xfer = ctrl[UWR_CTRL_XFER];

   // Register decode
   wire wr_ctrl = reg_wr && (reg_addr == UWR_ADDR_CTRL);
   wire wr_baud = reg_wr && (reg_addr == UWR_ADDR_BAUD);
   wire wr_stat = reg_wr && (reg_addr == UWR_ADDR_STAT);
   wire wr_mask = reg_wr && (reg_addr == UWR_ADDR_MASK);
   wire wr_rtcp = reg_wr && (reg_addr == UWR_ADDR_RTCP);
   wire wr_txd = reg_wr && (reg_addr == UWR_ADDR_TXD);

   // -------------------------------------------------------------
   // Wake sequencer
   // -------------------------------------------------------------
   logic wake_evt;
   logic clk_ready;
   logic sleep_now;

   uwr_wake #(.WAKE_CYC(UWR_WAKE_CYC)) u_wake
   (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .sleep_req(ctrl[UWR_CTRL_STBY]),
      .wake_evt(wake_evt),
      .asleep(sleep_now),
      .clk_ready(clk_ready)
   );

   // -------------------------------------------------------------
   // Sample tick divider
   // -------------------------------------------------------------
   logic [15:0] div_cnt;
   wire tick = (div_cnt == 16'h0000);
   // Receiver keeps sampling while asleep only if start detect is on
   wire rx_live = rx_en && (!sleep_now || sfde); // R7

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         div_cnt <= 16'h0000;
      else if (clk_en)
         div_cnt <= tick ? baud_div : div_cnt - 16'h0001; // R1 R9
   end

   // -------------------------------------------------------------
   // Receive state machine
   // -------------------------------------------------------------
   uwr_rx_state_t state;
   uwr_rx_state_t next_state;
   logic [3:0] smp;
   logic [2:0] bitn;
   logic [2:0] votes;
   logic [7:0] shreg;

   // Samples per bit and vote window depend on speed mode
   wire [3:0] smp_last = dspd ? 4'(UWR_OVS_DOUBLE - 1)
                              : 4'(UWR_OVS_NORMAL - 1); // R1
   wire [3:0] vote_a = dspd ? 4'h3 : 4'h7; // R2
   wire [3:0] vote_c = dspd ? 4'h5 : 4'h9; // R2
   wire in_vote = (smp >= vote_a) && (smp <= vote_c);
   wire [1:0] low_cnt = 2'(!votes[0]) + 2'(!votes[1]) + 2'(!votes[2]);
   wire bit_low = (low_cnt >= 2'h2); // R3
   wire start_fall = rx_prev && !rx_s;
   wire at_end = tick && (smp == smp_last);
   wire start_ok = (state == UWR_START) && at_end && bit_low; // R3
   wire start_bad = (state == UWR_START) && at_end && !bit_low; // R4
   wire byte_done = (state == UWR_STOP) && at_end;

   always_comb
   begin
      next_state = state;
      case (state)
         UWR_IDLE:
            if (rx_live && start_fall)
               next_state = UWR_START;
         UWR_START:
            if (start_ok)
               next_state = UWR_DATA;
            else if (start_bad)
               next_state = UWR_IDLE; // R4
         UWR_DATA:
            if (at_end && bitn == 3'h7)
               next_state = UWR_STOP;
         UWR_STOP:
            if (at_end)
               next_state = UWR_IDLE;
         default:
            next_state = UWR_IDLE;
      endcase
      if (!rx_live)
         next_state = UWR_IDLE;
   end

   // Sample counter, votes and shift register
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= UWR_IDLE;
         smp <= 4'h0;
         bitn <= 3'h0;
         votes <= 3'h7;
         shreg <= 8'h00;
         rx_prev <= 1'b1;
      end
      else if (clk_en)
      begin
         rx_prev <= rx_s;
         state <= next_state;
         if (state == UWR_IDLE)
         begin
            smp <= 4'h0;
            bitn <= 3'h0;
         end
         else if (tick)
         begin
            if (in_vote)
               votes <= {votes[1:0], rx_s}; // R2
            smp <= (smp == smp_last) ? 4'h0 : smp + 4'h1;
            if (at_end && state == UWR_DATA)
            begin
               shreg <= {bit_low ? 1'b0 : 1'b1, shreg[7:1]};
               bitn <= bitn + 3'h1;
            end
         end
      end
   end

   // -------------------------------------------------------------
   // Events, status, interrupt, wake
   // -------------------------------------------------------------
   wire rtc_ovf = (rtc_cnt == 32'h00000000);
   wire rtc_run = !sleep_now || ctrl[UWR_CTRL_RUN_IN_STANDBY]; // R10
   wire motion_evt = motion_prev != motion_s; // R11
   wire sof_evt = start_fall && (state == UWR_IDLE) && rx_live
                  && sleep_now && sfde;
   wire frame_err = byte_done && !bit_low ? 1'b0 : byte_done && bit_low;
   logic [4:0] evt;
   assign evt[UWR_ST_RXC] = byte_done && !bit_low;
   assign evt[UWR_ST_RXS] = sof_evt;
   assign evt[UWR_ST_RTC] = rtc_ovf && rtc_run && clk_en;
   assign evt[UWR_ST_PIN] = motion_evt;
   assign evt[UWR_ST_FERR] = frame_err;
   // Start and complete share one line; the start flag still wakes
   assign wake_evt = sof_evt || rtc_ovf && rtc_run || motion_evt; // R7 R10 R11

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         status <= 5'h00;
         rtc_cnt <= RTC_PERIOD;
         motion_prev <= 1'b1;
         rx_data <= 8'h00;
      end
      else if (clk_en)
      begin
         motion_prev <= motion_s;
         // Set wins over a write-one clear in the same cycle
         status <= (status & ~(wr_stat ? reg_wdata[4:0] : 5'h00)) | evt; // R6
         if (rtc_run)
            rtc_cnt <= rtc_ovf ? rtc_period : rtc_cnt - 32'h00000001; // R10
         if (evt[UWR_ST_RXC])
            rx_data <= shreg; // R7
      end
   end

   // -------------------------------------------------------------
   // Software registers and outputs
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ctrl <= UWR_CTRL_RESET;
         baud_div <= BAUD_DIV;
         mask <= UWR_MASK_RESET;
         rtc_period <= RTC_PERIOD;
         reg_rdata <= 32'h00000000;
         irq <= 1'b0;
         asleep <= 1'b0;
         host_rx_indication <= 1'b1;
         tx_req <= 1'b0;
         tx_byte <= 8'h00;
      end
      else if (clk_en)
      begin
         if (wr_ctrl)
            ctrl <= reg_wdata[7:0];
         else if (wake_evt)
            ctrl[UWR_CTRL_STBY] <= 1'b0;
         if (wr_baud)
            baud_div <= reg_wdata[15:0];
         if (wr_mask)
            mask <= reg_wdata[4:0];
         if (wr_rtcp)
            rtc_period <= reg_wdata;
         // One shared line, gated by the mask: start irq masked off
         irq <= |(status & mask) && clk_ready; // R5 R6
         asleep <= sleep_now;
         // Low opens the module's receive path for a transfer
         host_rx_indication <= !(xfer && link_up); // R14 R12 R13
         // Data only while the radio link is up; config via same path
         tx_req <= wr_txd && link_up && xfer; // R15 R16
         if (wr_txd)
            tx_byte <= reg_wdata[7:0];
         reg_rdata <= 32'h00000000;
         if (reg_rd)
         begin
            case (reg_addr)
               UWR_ADDR_CTRL: reg_rdata <= {24'h000000, ctrl};
               UWR_ADDR_BAUD: reg_rdata <= {16'h0000, baud_div};
               UWR_ADDR_STAT: reg_rdata <= {27'h0000000, status};
               UWR_ADDR_MASK: reg_rdata <= {27'h0000000, mask};
               UWR_ADDR_DATA: reg_rdata <= {24'h000000, rx_data};
               UWR_ADDR_RTCP: reg_rdata <= rtc_period;
               default: reg_rdata <= 32'h00000000;
            endcase
         end
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   reject_idle_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R4
      clk_en && start_bad |=> state == UWR_IDLE)
      else $error("rejected start did not return to idle");

   reject_quiet_a: assert property (@(posedge sys_clk) // R4
      disable iff (!rstn) start_bad |-> !evt[UWR_ST_RXC])
      else $error("rejected start raised receive event");

   // Majority worked out from the vote bits, not from the adder
   vote_major_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R3
      start_ok |-> (!votes[0] && !votes[1]) || (!votes[0] && !votes[2])
         || (!votes[1] && !votes[2]))
      else $error("start accepted without majority");

   // Window sits on the middle three samples of the bit
   vote_window_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R2
      tick && in_vote && state != UWR_IDLE |-> (dspd
         ? (smp >= 4'(UWR_OVS_DOUBLE / 2 - 1)
            && smp <= 4'(UWR_OVS_DOUBLE / 2 + 1))
         : (smp >= 4'(UWR_OVS_NORMAL / 2 - 1)
            && smp <= 4'(UWR_OVS_NORMAL / 2 + 1))))
      else $error("vote outside window");

   sample_wrap_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R1
      state != UWR_IDLE |-> smp <= (dspd ? 4'h7 : 4'hF))
      else $error("sample count beyond oversampling");

   shared_irq_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R6
      clk_en && status[UWR_ST_RXC] && mask[UWR_ST_RXC] && clk_ready
      |=> irq)
      else $error("receive complete did not raise line");

   sof_wake_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R7
      clk_en && sof_evt |=> !sleep_now)
      else $error("start of frame did not wake");

   // Six sample periods of the default divider
   wake_time_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R8
      clk_en && sof_evt |-> ##[1:246] clk_ready)
      else $error("wake took too long");

   ind_low_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R14
      tx_req |-> !host_rx_indication)
      else $error("transfer with indication high");

endmodule

// *** tb/uwr_radio.sv ***
// Behavioural radio module on the far side of the serial link
`timescale 1ns/1ps
module uwr_radio
(
   // Clock
   input wire logic sys_clk,
   // Serial link toward the host
   output logic serial_rx,
   // Host side controls
   input wire logic host_rx_indication,
   input wire logic tx_req,
   input wire logic [7:0] tx_byte,
   // Observation
   output logic [7:0] got_byte,
   output int got_cnt,
   output int bad_cnt
);
   // ---------------------------------------------
   // Line driver
   // ---------------------------------------------
   // Idle level of the link is high between frames
   initial
   begin
      serial_rx = 1'b1;
      got_byte = 8'h00;
      got_cnt = 0;
      bad_cnt = 0;
   end

   // One frame, start low, data LSB first, then stop
   task automatic send(input logic [7:0] d, input int bt, input logic stop);
      logic [9:0] f;
      f = {stop, d, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         serial_rx <= f[i];
         repeat (bt) @(posedge sys_clk);
      end
      serial_rx <= 1'b1;
   endtask

   // Short low glitch, too short or just long enough for a start
   task automatic pulse(input int n);
      serial_rx <= 1'b0;
      repeat (n) @(posedge sys_clk);
      serial_rx <= 1'b1;
   endtask

   // ---------------------------------------------
   // Receiver side of the module
   // ---------------------------------------------
   // Data offered while the indication is high is lost, so count it
   always @(posedge sys_clk)
   begin
      if (tx_req === 1'b1)
      begin
         if (host_rx_indication !== 1'b0)
            bad_cnt <= bad_cnt + 1;
         else
         begin
            got_byte <= tx_byte;
            got_cnt <= got_cnt + 1;
         end
      end
   end
endmodule

// *** tb/uwr_top_test.sv ***
// Self-checking testbench for the serial wake receiver
`timescale 1ns/1ps
module uwr_top_test
   import uwr_pkg::*;
;
   localparam int TICK = int'(UWR_BAUD_RESET) + 1;
   localparam int BITN = UWR_OVS_NORMAL * TICK;
   logic sys_clk, rstn, clk_en, reg_wr, reg_rd, serial_rx, motion_int;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic host_rx_indication, irq, asleep, tx_req;
   logic [7:0] tx_byte, got_byte;
   int got_cnt, bad_cnt, mismatches, compares;

   // ---------------------------------------------
   // Design, partner, clock
   // ---------------------------------------------
   uwr_top u_dut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_rx(serial_rx),
      .motion_int(motion_int), .host_rx_indication(host_rx_indication),
      .irq(irq), .asleep(asleep), .tx_req(tx_req), .tx_byte(tx_byte));

   uwr_radio u_radio (.sys_clk(sys_clk), .serial_rx(serial_rx),
      .host_rx_indication(host_rx_indication), .tx_req(tx_req),
      .tx_byte(tx_byte), .got_byte(got_byte), .got_cnt(got_cnt),
      .bad_cnt(bad_cnt));

   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // ---------------------------------------------
   // Shared helpers
   // ---------------------------------------------
   task automatic check(input logic [31:0] got, exp, input string what);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp, "register read");
   endtask

   // Bounded wait for the shared interrupt line
   task automatic wait_irq(input int n);
      int i;
      i = 0;
      while (irq !== 1'b1 && i < n)
      begin
         @(posedge sys_clk);
         i++;
      end
      check(32'(irq), 32'h1, "irq raised");
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset;
      check(32'(host_rx_indication), 32'h1, "indication idle");
      check(32'(irq), 32'h0, "irq idle");
      rd(UWR_ADDR_CTRL, 32'h0);
      rd(UWR_ADDR_BAUD, 32'(UWR_BAUD_RESET));
      rd(UWR_ADDR_MASK, 32'h0);
      rd(UWR_ADDR_RTCP, UWR_RTC_RESET);
      rd(4'h7, 32'h0);
      // A write while the enable is low must leave no trace
      clk_en <= 1'b0;
      wr(UWR_ADDR_CTRL, 32'h60);
      clk_en <= 1'b1;
      rd(UWR_ADDR_CTRL, 32'h0);
      check(32'(host_rx_indication), 32'h1, "frozen line");
      $display("test reset done");
   endtask

   // Plain byte at 16x, then write-one clear drops the line
   task automatic t_rx;
      wr(UWR_ADDR_CTRL, 32'h01);
      wr(UWR_ADDR_MASK, 32'h01);
      u_radio.send(8'hA5, BITN, 1'b1);
      wait_irq(BITN);
      rd(UWR_ADDR_STAT, 32'h01);
      rd(UWR_ADDR_DATA, 32'hA5);
      wr(UWR_ADDR_STAT, 32'h01);
      rd(UWR_ADDR_STAT, 32'h00);
      check(32'(irq), 32'h0, "irq cleared");
      $display("test rx done");
   endtask

   // A short low pulse is rejected, a pulse of nine and a half samples is a start
   task automatic t_votes;
      u_radio.pulse(6 * TICK);
      repeat (11 * BITN) @(posedge sys_clk);
      rd(UWR_ADDR_STAT, 32'h00);
      check(32'(irq), 32'h0, "no event");
      u_radio.pulse(19 * TICK / 2);
      repeat (11 * BITN) @(posedge sys_clk);
      rd(UWR_ADDR_STAT, 32'h01);
      rd(UWR_ADDR_DATA, 32'hFF);
      wr(UWR_ADDR_STAT, 32'h01);
      $display("test votes done");
   endtask

   task automatic t_dspd;
      wr(UWR_ADDR_CTRL, 32'h03);
      u_radio.send(8'hC3, UWR_OVS_DOUBLE * TICK, 1'b1);
      wait_irq(BITN);
      rd(UWR_ADDR_DATA, 32'hC3);
      wr(UWR_ADDR_STAT, 32'h01);
      wr(UWR_ADDR_CTRL, 32'h01);
      $display("test double speed done");
   endtask

   // Low stop bit: frame error only, masked until unmasked
   task automatic t_ferr;
      wr(UWR_ADDR_MASK, 32'h00);
      u_radio.send(8'h0F, BITN, 1'b0);
      repeat (BITN) @(posedge sys_clk);
      rd(UWR_ADDR_STAT, 32'h10);
      check(32'(irq), 32'h0, "masked event");
      wr(UWR_ADDR_MASK, 32'h10);
      wait_irq(4);
      wr(UWR_ADDR_STAT, 32'h10);
      $display("test frame error done");
   endtask

   // Byte arriving in standby wakes the host and is kept whole
   task automatic t_wake;
      wr(UWR_ADDR_MASK, 32'h01);
      wr(UWR_ADDR_CTRL, 32'h0D);
      repeat (3) @(posedge sys_clk);
      check(32'(asleep), 32'h1, "asleep");
      u_radio.send(8'h3C, BITN, 1'b1);
      wait_irq(BITN);
      check(32'(asleep), 32'h0, "woken");
      rd(UWR_ADDR_DATA, 32'h3C);
      rd(UWR_ADDR_STAT, 32'h03);
      wr(UWR_ADDR_STAT, 32'h03);
      $display("test start wake done");
   endtask

   task automatic t_motion;
      wr(UWR_ADDR_MASK, 32'h08);
      wr(UWR_ADDR_CTRL, 32'h08);
      repeat (3) @(posedge sys_clk);
      check(32'(asleep), 32'h1, "asleep");
      // Sensor line idles high and pulls low on motion
      motion_int <= 1'b0;
      wait_irq(400);
      check(32'(asleep), 32'h0, "woken");
      rd(UWR_ADDR_STAT, 32'h08);
      wr(UWR_ADDR_STAT, 32'h08);
      $display("test motion done");
   endtask

   // Nothing leaves without a link; config command with the line low
   task automatic t_tx;
      wr(UWR_ADDR_CTRL, 32'h40);
      wr(UWR_ADDR_TXD, 32'h55);
      repeat (3) @(posedge sys_clk);
      check(32'(got_cnt), 32'h0, "tx without link");
      check(32'(host_rx_indication), 32'h1, "line high");
      wr(UWR_ADDR_CTRL, 32'h60);
      repeat (3) @(posedge sys_clk);
      check(32'(host_rx_indication), 32'h0, "line low");
      wr(UWR_ADDR_TXD, 32'h53);
      wr(UWR_ADDR_TXD, 32'h4F);
      wr(UWR_ADDR_TXD, 32'h2C);
      wr(UWR_ADDR_TXD, 32'h31);
      repeat (3) @(posedge sys_clk);
      check(32'(got_cnt), 32'h4, "bytes taken");
      check(32'(got_byte), 32'h31, "last byte");
      wr(UWR_ADDR_CTRL, 32'h20);
      repeat (3) @(posedge sys_clk);
      check(32'(host_rx_indication), 32'h1, "line high");
      check(32'(bad_cnt), 32'h0, "data while high");
      $display("test transfer done");
   endtask

   // Counter keeps running in standby and its overflow wakes
   task automatic t_rtc;
      wr(UWR_ADDR_RTCP, 32'd100);
      wr(UWR_ADDR_MASK, 32'h04);
      wr(UWR_ADDR_CTRL, 32'h18);
      // New period applies at the next reload; the reset count runs out first
      wait_irq(70000);
      check(32'(asleep), 32'h0, "woken");
      wr(UWR_ADDR_RTCP, UWR_RTC_RESET);
      rd(UWR_ADDR_STAT, 32'h04);
      $display("test counter done");
   endtask

   // ---------------------------------------------
   // Sequence, watchdog, verdict
   // ---------------------------------------------
   task automatic test_done;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      mismatches = 0;
      compares = 0;
      rstn = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      motion_int = 1'b1;
      clk_en = 1'b1;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      t_reset();
      t_rx();
      t_votes();
      t_dspd();
      t_ferr();
      t_wake();
      t_motion();
      t_tx();
      t_rtc();
      test_done();
   end

   // Tests need roughly sixty-six thousand cycles
   initial
   begin
      repeat (95000) @(posedge sys_clk);
      mismatches++;
      $display("ERROR at %0t: watchdog expired", $time);
      test_done();
   end
endmodule
